// file: hw/dcd_decoder.sv
// Command decoder and clock-enable state logic of the memory device
// How it works
// - Decode pins sampled at every rising edge
// - RAS CAS WE patterns map to commands
// - Mode set: bank bits pick register
// - ZQ: A10 high long, low short
// - A10 auto precharge; A12 burst when OTF
// - Precharge A10 high means all banks
// - Bursts always run to completion
// - NOP registers nothing, disturbs nothing
// - Deselect behaves exactly like NOP
// - Active low asynchronous reset
// - ODT ignored by decoding and CKE
// - No refresh starts in power-down
// - Self refresh exit without clock
// - CKE judged from previous and present edge
// - CKE fall picks power-down kind
// - CKE low holds; rising NOP exits
// - Idle needs banks closed, all quiet
// - Address widths set by organisation
`timescale 1ns/1ns
`default_nettype none
module dcd_decoder
   import dcd_pkg::*;
#(
   parameter int BA_W   = DCD_BA_W_DEF,
   parameter int ADDR_W = DCD_ADDR_W_DEF,
   parameter int NBANK  = DCD_NBANK_DEF
)(
   input  wire logic              MCLK_IN,
   input  wire logic              RST_B_IN,
   input  wire logic              CKE_IN,
   input  wire logic              CS_B_IN,
   input  wire logic              RAS_B_IN,
   input  wire logic              CAS_B_IN,
   input  wire logic              WE_B_IN,
   input  wire logic [BA_W-1:0]   BA_IN,
   input  wire logic [ADDR_W-1:0] ADDR_IN,
   input  wire logic              ODT_IN,
   input  wire logic              MR0_OTF_IN,
   output logic                   CMD_STB_OUT,
   output logic [3:0]             CMD_OUT,
   output logic [BA_W-1:0]        BANK_OUT,
   output logic [ADDR_W-1:0]      ADDR_OUT,
   output logic [DCD_MR_SEL_W-1:0] MR_SEL_OUT,
   output logic                   AUTO_PRE_OUT,
   output logic                   BL8_OUT,
   output logic                   ZQ_LONG_OUT,
   output logic                   ALL_BANKS_OUT,
   output logic [2:0]             PWR_STATE_OUT,
   output logic [1:0]             PD_KIND_OUT,
   output logic [NBANK-1:0]       BANK_OPEN_OUT,
   output logic                   IDLE_OUT,
   output logic                   BUSY_OUT
);
   // ODT is a pin of the device but plays no part here
   logic odt_unused;
   assign odt_unused = ODT_IN;

   dcd_busy_if busy ();

   dcd_tracker u_tracker (
      .clk_in   (MCLK_IN),
      .rst_b_in (RST_B_IN),
      .bus      (busy)
   );

   logic              cke_prev_r;
   dcd_pwr_t          pwr_r;
   dcd_pwr_t          pwr_nxt;
   dcd_pdkind_t       pdk_r;
   dcd_pdkind_t       pdk_nxt;
   logic [NBANK-1:0]  open_r;
   logic [NBANK-1:0]  open_nxt;
   logic              stb_r;
   dcd_cmd_t          cmd_r;
   dcd_cmd_t          cmd_nxt;
   logic [BA_W-1:0]   bank_r;
   logic [ADDR_W-1:0] addr_r;
   logic              ap_r;
   logic              bl8_r;
   logic              zql_r;
   logic              all_r;
   logic              idle_r;
   logic              busy_r;

   // Pin pattern decode, CKE high on both edges
   function automatic dcd_cmd_t base_cmd(input logic cs_b, input logic ras_b,
                                         input logic cas_b, input logic we_b,
                                         input logic a10);
      if (cs_b)
         base_cmd = DCD_CMD_NONE;
      else
         case ({ras_b, cas_b, we_b})
            3'b000:  base_cmd = DCD_CMD_MRS;
            3'b001:  base_cmd = DCD_CMD_REF;
            3'b010:  base_cmd = a10 ? DCD_CMD_PREA : DCD_CMD_PRE;
            3'b011:  base_cmd = DCD_CMD_ACT;
            3'b100:  base_cmd = DCD_CMD_WR;
            3'b101:  base_cmd = DCD_CMD_RD;
            3'b110:  base_cmd = a10 ? DCD_CMD_ZQCL : DCD_CMD_ZQCS;
            default: base_cmd = DCD_CMD_NONE;
         endcase
   endfunction

   wire       a10        = ADDR_IN[DCD_A10_POS];
   wire       a12        = ADDR_IN[DCD_A12_POS];
   wire       is_nop     = CS_B_IN || (RAS_B_IN && CAS_B_IN && WE_B_IN);
   wire       is_ref     = !CS_B_IN && !RAS_B_IN && !CAS_B_IN && WE_B_IN;
   wire       cke_hh     = cke_prev_r && CKE_IN;
   wire       cke_hl     = cke_prev_r && !CKE_IN;
   wire       cke_lh     = !cke_prev_r && CKE_IN;
   wire dcd_cmd_t pin_cmd = base_cmd(CS_B_IN, RAS_B_IN, CAS_B_IN, WE_B_IN, a10);
   wire       any_open   = |open_r;
   wire       quiet      = !busy.reading && !busy.writing && !busy.precharging;
   wire       idle_now   = !any_open && quiet && !busy.refreshing && !busy.exit_wait;
   wire       rw_cmd     = (pin_cmd == DCD_CMD_RD) || (pin_cmd == DCD_CMD_WR);
   // Burst is fixed at eight when on-the-fly selection is off
   wire       bl8_sel    = MR0_OTF_IN ? a12 : 1'b1;
   // Power state strobes carry no address, so the fields keep the last command's
   wire       pin_taken  = (cmd_nxt == pin_cmd) && (cmd_nxt != DCD_CMD_NONE);

   // CKE state machine: evaluated against the state just before this edge
   always_comb begin
      pwr_nxt = pwr_r;
      pdk_nxt = pdk_r;
      cmd_nxt = DCD_CMD_NONE;
      case (pwr_r)
         DCD_ST_ACTIVE: begin
            if (cke_hh) begin
               cmd_nxt = pin_cmd;
            end else if (cke_hl && is_ref && idle_now) begin
               pwr_nxt = DCD_ST_SR;
               cmd_nxt = DCD_CMD_SRE;
            end else if (cke_hl && is_nop) begin
               pwr_nxt = DCD_ST_PD;
               cmd_nxt = DCD_CMD_PDE;
               if (any_open && quiet)
                  pdk_nxt = DCD_PD_ACTIVE;
               else if (!quiet)
                  pdk_nxt = DCD_PD_PLAIN;
               else
                  pdk_nxt = DCD_PD_PRECH;
            end
         end
         DCD_ST_PD: begin
            // CKE held low keeps power-down whatever the command
            if (cke_lh && is_nop) begin
               pwr_nxt = DCD_ST_ACTIVE;
               pdk_nxt = DCD_PD_NONE;
               cmd_nxt = DCD_CMD_PDX;
            end
         end
         DCD_ST_SR: begin
            // Clock may have stopped, so the exit needs no registered low CKE before it
            if (CKE_IN && is_nop) begin
               pwr_nxt = DCD_ST_ACTIVE;
               cmd_nxt = DCD_CMD_SRX;
            end
         end
         default: begin
            pwr_nxt = DCD_ST_ACTIVE;
            pdk_nxt = DCD_PD_NONE;
         end
      endcase
   end

   // Bank open map; all-bank precharge ignores the bank bits
   always_comb begin
      open_nxt = open_r;
      case (cmd_nxt)
         DCD_CMD_ACT:  open_nxt[BA_IN] = 1'b1;
         DCD_CMD_PRE:  open_nxt[BA_IN] = 1'b0;
         DCD_CMD_PREA: open_nxt = '0;
         DCD_CMD_RD,
         DCD_CMD_WR:   if (a10) open_nxt[BA_IN] = 1'b0;
         default:      open_nxt = open_r;
      endcase
   end

   assign busy.start_rd   = cmd_nxt == DCD_CMD_RD;
   assign busy.start_wr   = cmd_nxt == DCD_CMD_WR;
   assign busy.len8       = bl8_sel;
   assign busy.start_pre  = (cmd_nxt == DCD_CMD_PRE) || (cmd_nxt == DCD_CMD_PREA)
                            || (rw_cmd && cmd_nxt == pin_cmd && a10);
   // Refresh starts only from a decoded command, never in power-down
   assign busy.start_ref  = cmd_nxt == DCD_CMD_REF;
   assign busy.start_exit = (cmd_nxt == DCD_CMD_PDX) || (cmd_nxt == DCD_CMD_SRX);

   always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         cke_prev_r <= 1'b0;
         pwr_r      <= DCD_ST_ACTIVE;
         pdk_r      <= DCD_PD_NONE;
         open_r     <= '0;
      end else begin
         cke_prev_r <= CKE_IN;
         pwr_r      <= pwr_nxt;
         pdk_r      <= pdk_nxt;
         open_r     <= open_nxt;
      end
   end

   always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         stb_r  <= 1'b0;
         cmd_r  <= DCD_CMD_NONE;
         bank_r <= '0;
         addr_r <= '0;
         ap_r   <= 1'b0;
         bl8_r  <= 1'b0;
         zql_r  <= 1'b0;
         all_r  <= 1'b0;
      end else begin
         stb_r <= cmd_nxt != DCD_CMD_NONE;
         cmd_r <= cmd_nxt;
         if (pin_taken) begin
            bank_r <= BA_IN;
            addr_r <= ADDR_IN;
            ap_r   <= rw_cmd && a10;
            bl8_r  <= rw_cmd && bl8_sel;
            zql_r  <= cmd_nxt == DCD_CMD_ZQCL;
            all_r  <= cmd_nxt == DCD_CMD_PREA;
         end
      end
   end

   always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         idle_r <= 1'b0;
         busy_r <= 1'b0;
      end else begin
         // Any command this edge starts fresh timing, so idle waits a cycle
         idle_r <= idle_now && CKE_IN && (pwr_nxt == DCD_ST_ACTIVE)
                   && (cmd_nxt == DCD_CMD_NONE);
         // A read, write or precharge start shows at once rather than a cycle after the counter loads
         busy_r <= !quiet || busy.start_rd || busy.start_wr || busy.start_pre;
      end
   end

   assign CMD_STB_OUT   = stb_r;
   assign CMD_OUT       = cmd_r;
   assign BANK_OUT      = bank_r;
   assign ADDR_OUT      = addr_r;
   // Mode register select is the low bank bits
   assign MR_SEL_OUT    = bank_r[DCD_MR_SEL_W-1:0];
   assign AUTO_PRE_OUT  = ap_r;
   assign BL8_OUT       = bl8_r;
   assign ZQ_LONG_OUT   = zql_r;
   assign ALL_BANKS_OUT = all_r;
   assign PWR_STATE_OUT = pwr_r;
   assign PD_KIND_OUT   = pdk_r;
   assign BANK_OPEN_OUT = open_r;
   assign IDLE_OUT      = idle_r;
   assign BUSY_OUT      = busy_r;

   nop_no_strobe_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
      (cke_hh && pwr_r == DCD_ST_ACTIVE && is_nop) |=> !CMD_STB_OUT && $stable(BANK_OUT))
      else $error("NOP or deselect raised a strobe");
   prea_all_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
      (cke_hh && pwr_r == DCD_ST_ACTIVE && pin_cmd == DCD_CMD_PREA)
      |=> BANK_OPEN_OUT == '0 && ALL_BANKS_OUT)
      else $error("All-bank precharge left a bank open");
   zq_long_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
      (CMD_STB_OUT && CMD_OUT == DCD_CMD_ZQCS) |-> !ZQ_LONG_OUT)
      else $error("Short calibration flagged long");
   pd_hold_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
      (pwr_r == DCD_ST_PD && !cke_prev_r && !CKE_IN) |=> PWR_STATE_OUT == DCD_ST_PD)
      else $error("Power-down left with CKE low");
   no_ref_pd_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
      (pwr_r == DCD_ST_PD) |-> !busy.start_ref)
      else $error("Refresh started in power-down");
   pd_entry_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
      (pwr_r == DCD_ST_ACTIVE && cke_hl && is_nop && !(is_ref && idle_now))
      |=> PWR_STATE_OUT == DCD_ST_PD && CMD_OUT == DCD_CMD_PDE)
      else $error("Power-down entry missed");
   burst_otf_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
      (cke_hh && pwr_r == DCD_ST_ACTIVE && pin_cmd == DCD_CMD_RD && MR0_OTF_IN)
      |=> BL8_OUT == $past(a12))
      else $error("Burst choice not taken from A12");
   idle_cond_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
      IDLE_OUT |-> BANK_OPEN_OUT == '0 && !BUSY_OUT)
      else $error("Idle reported with activity");
   mrs_sel_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
      (cke_hh && pwr_r == DCD_ST_ACTIVE && pin_cmd == DCD_CMD_MRS)
      |=> MR_SEL_OUT == $past(BA_IN[1:0]) && ADDR_OUT == $past(ADDR_IN))
      else $error("Mode set select or opcode wrong");
   des_no_stb_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
      (cke_hh && pwr_r == DCD_ST_ACTIVE && CS_B_IN)
      |=> !CMD_STB_OUT && CMD_OUT == DCD_CMD_NONE && $stable(ADDR_OUT))
      else $error("Deselect raised a strobe");
   act_open_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
      (cke_hh && pwr_r == DCD_ST_ACTIVE && pin_cmd == DCD_CMD_ACT)
      |=> CMD_OUT == DCD_CMD_ACT && BANK_OUT == $past(BA_IN) && BANK_OPEN_OUT[BANK_OUT])
      else $error("Activate did not open its bank");
   pre_one_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
      (cke_hh && pwr_r == DCD_ST_ACTIVE && pin_cmd == DCD_CMD_PRE)
      |=> !BANK_OPEN_OUT[BANK_OUT] && !ALL_BANKS_OUT)
      else $error("Single-bank precharge left its bank open");
   auto_pre_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
      (cke_hh && pwr_r == DCD_ST_ACTIVE && rw_cmd && a10)
      |=> AUTO_PRE_OUT && !BANK_OPEN_OUT[BANK_OUT])
      else $error("Auto precharge not applied");
   fixed_burst_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
      (cke_hh && pwr_r == DCD_ST_ACTIVE && rw_cmd && !MR0_OTF_IN) |=> BL8_OUT)
      else $error("Fixed burst not reported as eight");
   zq_long_set_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
      (cke_hh && pwr_r == DCD_ST_ACTIVE && pin_cmd == DCD_CMD_ZQCL)
      |=> CMD_OUT == DCD_CMD_ZQCL && ZQ_LONG_OUT)
      else $error("Long calibration not flagged");
   sr_entry_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
      (pwr_r == DCD_ST_ACTIVE && cke_hl && is_ref && idle_now)
      |=> PWR_STATE_OUT == DCD_ST_SR && CMD_OUT == DCD_CMD_SRE)
      else $error("Self refresh entry missed");
   sr_hold_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
      (pwr_r == DCD_ST_SR && !CKE_IN) |=> PWR_STATE_OUT == DCD_ST_SR && !CMD_STB_OUT)
      else $error("Self refresh left with CKE low");
   sr_exit_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
      (pwr_r == DCD_ST_SR && CKE_IN && is_nop)
      |=> PWR_STATE_OUT == DCD_ST_ACTIVE && CMD_OUT == DCD_CMD_SRX)
      else $error("Self refresh exit missed");
   pd_exit_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
      (pwr_r == DCD_ST_PD && cke_lh && is_nop)
      |=> PWR_STATE_OUT == DCD_ST_ACTIVE && CMD_OUT == DCD_CMD_PDX)
      else $error("Power-down exit missed");
   pd_quiet_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
      (pwr_r == DCD_ST_PD && !CKE_IN) |=> !CMD_STB_OUT && $stable(BANK_OPEN_OUT))
      else $error("Command taken in power-down");
   pd_kind_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
      (pwr_r == DCD_ST_ACTIVE && cke_hl && is_nop && any_open && quiet)
      |=> PD_KIND_OUT == DCD_PD_ACTIVE)
      else $error("Active power-down not reported");
   busy_run_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
      (busy.reading || busy.writing || busy.precharging) |=> BUSY_OUT)
      else $error("Running burst not reported busy");
   strobe_code_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
      CMD_STB_OUT == (CMD_OUT != DCD_CMD_NONE))
      else $error("Strobe and command code disagree");
   idle_gap_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
      (cke_hh && pwr_r == DCD_ST_ACTIVE && pin_cmd != DCD_CMD_NONE) |=> !IDLE_OUT)
      else $error("Idle reported right after a command");
endmodule // dcd_decoder
`default_nettype wire

// file: hw/dcd_pkg.sv
// Package with command codes, field positions and timing counts of the command decoder
package dcd_pkg;
   localparam int DCD_BA_W_DEF   = 3;
   localparam int DCD_ADDR_W_DEF = 14;
   localparam int DCD_NBANK_DEF  = 8;
   localparam int DCD_A10_POS    = 10;
   localparam int DCD_A12_POS    = 12;
   localparam int DCD_MR_SEL_W   = 2;
   localparam int DCD_MR0_OTF_POS = 1;
   localparam int DCD_MR0_BL_LSB  = 0;
   // Burst length in clock edges (two data beats per edge)
   localparam int DCD_BL8_CYC    = 4;
   localparam int DCD_BC4_CYC    = 2;
   localparam int DCD_TRP_NS     = 15;
   localparam int DCD_CLK_NS     = 50;
   localparam int DCD_TRP_CYC    = (DCD_TRP_NS + DCD_CLK_NS - 1) / DCD_CLK_NS;
   localparam int DCD_TRFC_NS    = 160;
   localparam int DCD_TRFC_CYC   = (DCD_TRFC_NS + DCD_CLK_NS - 1) / DCD_CLK_NS;
   localparam int DCD_TXP_NS     = 24;
   localparam int DCD_TXP_CYC    = (DCD_TXP_NS + DCD_CLK_NS - 1) / DCD_CLK_NS;
   localparam int DCD_CNT_W      = 4;

   typedef enum logic [3:0] {
      DCD_CMD_NONE  = 4'h0,
      DCD_CMD_MRS   = 4'h1,
      DCD_CMD_REF   = 4'h2,
      DCD_CMD_PRE   = 4'h3,
      DCD_CMD_PREA  = 4'h4,
      DCD_CMD_ACT   = 4'h5,
      DCD_CMD_WR    = 4'h6,
      DCD_CMD_RD    = 4'h7,
      DCD_CMD_ZQCL  = 4'h8,
      DCD_CMD_ZQCS  = 4'h9,
      DCD_CMD_SRE   = 4'hA,
      DCD_CMD_SRX   = 4'hB,
      DCD_CMD_PDE   = 4'hC,
      DCD_CMD_PDX   = 4'hD
   } dcd_cmd_t;

   typedef enum logic [2:0] {
      DCD_ST_ACTIVE = 3'b000,
      DCD_ST_PD     = 3'b001,
      DCD_ST_SR     = 3'b010
   } dcd_pwr_t;

   typedef enum logic [1:0] {
      DCD_PD_NONE   = 2'b00,
      DCD_PD_ACTIVE = 2'b01,
      DCD_PD_PLAIN  = 2'b10,
      DCD_PD_PRECH  = 2'b11
   } dcd_pdkind_t;
endpackage

// file: hw/dcd_busy_if.sv
// Interface carrying activity status from the burst tracker to the decoder
`timescale 1ns/1ns
`default_nettype none
interface dcd_busy_if;
   logic start_rd;
   logic start_wr;
   logic start_pre;
   logic start_ref;
   logic len8;
   logic reading;
   logic writing;
   logic precharging;
   logic refreshing;
   logic exit_wait;
   logic start_exit;
   modport tracker (input start_rd, start_wr, start_pre, start_ref, len8, start_exit,
                    output reading, writing, precharging, refreshing, exit_wait);
   modport decoder (output start_rd, start_wr, start_pre, start_ref, len8, start_exit,
                    input reading, writing, precharging, refreshing, exit_wait);
endinterface
`default_nettype wire

// file: hw/dcd_tracker.sv
// Burst, precharge, refresh and exit timers of the command decoder
`timescale 1ns/1ns
`default_nettype none
module dcd_tracker
   import dcd_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_b_in,
   dcd_busy_if.tracker      bus
);
   logic [DCD_CNT_W-1:0] burst_r;
   logic [DCD_CNT_W-1:0] pre_r;
   logic [DCD_CNT_W-1:0] ref_r;
   logic [DCD_CNT_W-1:0] exit_r;
   logic                 wr_r;
   logic [DCD_CNT_W-1:0] burst_len;

   function automatic logic [DCD_CNT_W-1:0] dec(input logic [DCD_CNT_W-1:0] v);
      dec = (v != '0) ? v - 1'b1 : v;
   endfunction

   assign burst_len = bus.len8 ? DCD_CNT_W'(DCD_BL8_CYC) : DCD_CNT_W'(DCD_BC4_CYC);

   // A running burst is never cut short; new starts only reload after it ends
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         burst_r <= '0;
         wr_r    <= 1'b0;
      end else if ((bus.start_rd || bus.start_wr) && burst_r == '0) begin
         burst_r <= burst_len;
         wr_r    <= bus.start_wr;
      end else begin
         burst_r <= dec(burst_r);
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         pre_r  <= '0;
         ref_r  <= '0;
         exit_r <= '0;
      end else begin
         pre_r  <= bus.start_pre ? DCD_CNT_W'(DCD_TRP_CYC) : dec(pre_r);
         ref_r  <= bus.start_ref ? DCD_CNT_W'(DCD_TRFC_CYC) : dec(ref_r);
         exit_r <= bus.start_exit ? DCD_CNT_W'(DCD_TXP_CYC) : dec(exit_r);
      end
   end

   assign bus.reading     = (burst_r != '0) && !wr_r;
   assign bus.writing     = (burst_r != '0) && wr_r;
   assign bus.precharging = pre_r != '0;
   assign bus.refreshing  = ref_r != '0;
   assign bus.exit_wait   = exit_r != '0;

   burst_runs_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (bus.start_rd && burst_r == '0 && bus.len8) |=> (bus.reading [*4]) ##1 !bus.reading)
      else $error("BL8 read burst not held four edges");
endmodule // dcd_tracker
`default_nettype wire

// file: tb/dcd_ctl_model.sv
// Controller model driving the decoder's command pins
`timescale 1ns/1ns
`default_nettype none
module dcd_ctl_model
   import dcd_pkg::*;
#(
   parameter int BA_W = DCD_BA_W_DEF,
   parameter int AW   = DCD_ADDR_W_DEF,
   parameter int TCKE = 3
)(
   input  wire logic       clk_in,
   output logic            cke_out,
   output logic [3:0]      pins_out,
   output logic [BA_W-1:0] ba_out,
   output logic [AW-1:0]   addr_out,
   output logic            odt_out
);
   int cke_age = TCKE;
   initial begin
      cke_out = 1'b1;
      pins_out = 4'h7;
      ba_out = '0;
      addr_out = '0;
      odt_out = 1'b0;
   end
   // One whole cycle per command; the caller stands at a falling edge
   task automatic cycle(input logic k, input logic [3:0] p, input logic [BA_W-1:0] b,
                        input logic [AW-1:0] a, input logic o);
      cke_age = (k === cke_out) ? cke_age + 1 : 1;
      cke_out = k;
      pins_out = p;
      ba_out = b;
      addr_out = a;
      odt_out = o;
      @(posedge clk_in);
      @(negedge clk_in);
   endtask
   task automatic issue(input logic k, input logic [3:0] p, input logic [BA_W-1:0] b,
                        input logic [AW-1:0] a, input logic o);
      // A fresh CKE level is held over TCKE edges before it may move again
      while (k !== cke_out && cke_age < TCKE)
         cycle(cke_out, 4'h7, ~ba_out, ~addr_out, o);
      cycle(k, p, b, a, o);
   endtask
endmodule // dcd_ctl_model
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench of the command decoder
`timescale 1ns/1ns
`default_nettype none
module tb;
   import dcd_pkg::*;
   localparam int BW = DCD_BA_W_DEF;
   localparam int AW = DCD_ADDR_W_DEF;
   logic          clk = 1'b0;
   logic          rst_b = 1'b0;
   logic          otf = 1'b0;
   logic          cke, odt, stb, apre, bl8, zql, allb, idle, busy;
   logic [3:0]    pins, cmd;
   logic [BW-1:0] ba, bank, lb, b;
   logic [AW-1:0] addr, aout, la, a;
   logic [1:0]    mrsel, pdk;
   logic [2:0]    pwr;
   logic [7:0]    bop;
   logic [31:0]   rng = 32'h201f_93de;
   logic [31:0]   r;
   int            n_fail = 0;
   int            cmp_count = 0;

   always #25 clk = ~clk;

   dcd_ctl_model #(.BA_W(BW), .AW(AW)) ctl (.clk_in(clk), .cke_out(cke), .pins_out(pins),
      .ba_out(ba), .addr_out(addr), .odt_out(odt));
   dcd_decoder #(.BA_W(BW), .ADDR_W(AW)) dut (
      .MCLK_IN(clk), .RST_B_IN(rst_b), .CKE_IN(cke), .CS_B_IN(pins[3]),
      .RAS_B_IN(pins[2]), .CAS_B_IN(pins[1]), .WE_B_IN(pins[0]), .BA_IN(ba),
      .ADDR_IN(addr), .ODT_IN(odt), .MR0_OTF_IN(otf), .CMD_STB_OUT(stb), .CMD_OUT(cmd),
      .BANK_OUT(bank), .ADDR_OUT(aout), .MR_SEL_OUT(mrsel), .AUTO_PRE_OUT(apre),
      .BL8_OUT(bl8), .ZQ_LONG_OUT(zql), .ALL_BANKS_OUT(allb), .PWR_STATE_OUT(pwr),
      .PD_KIND_OUT(pdk), .BANK_OPEN_OUT(bop), .IDLE_OUT(idle), .BUSY_OUT(busy));

   function automatic logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   function automatic logic [3:0] exp_cmd(input logic [2:0] rcw, input logic a10);
      case (rcw)
         3'h0: return DCD_CMD_MRS;
         3'h1: return DCD_CMD_REF;
         3'h2: return a10 ? DCD_CMD_PREA : DCD_CMD_PRE;
         3'h3: return DCD_CMD_ACT;
         3'h4: return DCD_CMD_WR;
         3'h5: return DCD_CMD_RD;
         3'h6: return a10 ? DCD_CMD_ZQCL : DCD_CMD_ZQCS;
         default: return DCD_CMD_NONE;
      endcase
   endfunction

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // ODT is random on every command, so any leak into decoding shows up
   task automatic go(input logic [3:0] p, input logic [BW-1:0] bb, input logic [AW-1:0] aa);
      logic [3:0] e;
      e = p[3] ? DCD_CMD_NONE : exp_cmd(p[2:0], aa[DCD_A10_POS]);
      r = xs();
      ctl.issue(1'b1, p, bb, aa, r[0]);
      chk(cmd, e, "code");
      chk(stb, e != DCD_CMD_NONE, "strobe");
      if (e != DCD_CMD_NONE) begin
         lb = bb;
         la = aa;
      end
      chk({bank, aout}, {lb, la}, "fields");
   endtask

   task automatic nop(input logic k);
      r = xs();
      ctl.issue(k, 4'h7, r[AW+:BW], r[AW-1:0], r[31]);
   endtask

   // Bounded wait: refresh, calibration and bursts finish in a few cycles
   task automatic settle();
      for (int i = 0; i < 20 && idle !== 1'b1; i++)
         nop(1'b1);
      chk(idle, 1, "idle");
   endtask

   initial begin
      repeat (16) @(negedge clk);
      rst_b = 1'b1; // Stays high through normal operation
      nop(1'b1);
      nop(1'b1);
      for (int i = 0; i < 4; i++) begin
         r = xs();
         go(4'h0, BW'(i), r[AW-1:0]);
         chk(mrsel, i, "mode select");
      end
      for (int i = 0; i < 2; i++) begin
         r = xs();
         r[DCD_A10_POS] = i[0];
         go(4'h6, r[AW+:BW], r[AW-1:0]);
         chk(zql, i, "zq length");
         settle();
      end
      go(4'h1, '0, '0);
      settle();
      $display("test mode_zq_refresh done");
      r = xs();
      b = r[AW+:BW];
      go(4'h3, b, r[AW-1:0]); // Only closed banks are activated
      chk(bop[b], 1, "bank open");
      chk(idle, 0, "not idle");
      for (int i = 0; i < 12; i++) begin
         r = xs();
         otf = r[20];
         a = r[AW-1:0];
         a[DCD_A10_POS] = (i == 11);
         go(r[21] ? 4'h5 : 4'h4, b, a);
         chk({apre, bl8, busy}, {a[DCD_A10_POS], otf ? a[DCD_A12_POS] : 1'b1, 1'b1},
             "burst");
      end
      nop(1'b1);
      chk(busy, 1, "burst runs on");
      settle();
      chk(bop, 0, "auto precharge");
      $display("test bursts done");
      r = xs();
      go(4'h3, b, r[AW-1:0]);
      ctl.issue(1'b0, 4'h7, b, r[AW-1:0], 1'b1);
      chk({cmd, pwr, pdk}, {DCD_CMD_PDE, DCD_ST_PD, DCD_PD_ACTIVE}, "active pd");
      ctl.issue(1'b0, 4'h1, b, r[AW-1:0], 1'b0);
      chk({stb, pwr}, {1'b0, DCD_ST_PD}, "pd holds");
      ctl.issue(1'b1, {1'b1, r[2:0]}, ~b, ~r[AW-1:0], 1'b1);
      chk({cmd, pwr}, {DCD_CMD_PDX, DCD_ST_ACTIVE}, "pd exit");
      nop(1'b1);
      go(4'h5, b, '0);
      ctl.issue(1'b0, 4'h7, b, '0, 1'b0);
      chk(pdk, DCD_PD_PLAIN, "read pd");
      nop(1'b1);
      nop(1'b1);
      go(4'h3, b ^ BW'(1), r[AW-1:0]);
      go(4'h2, b, '0);
      chk(allb, 0, "one bank");
      nop(1'b1);
      chk({bop[b], bop[b ^ BW'(1)]}, 2'h1, "single bank");
      r = xs();
      r[DCD_A10_POS] = 1'b1;
      go(4'h2, r[AW+:BW], r[AW-1:0]);
      chk(allb, 1, "all banks");
      settle();
      chk(bop, 0, "all closed");
      ctl.issue(1'b0, 4'h7, '0, '0, 1'b1);
      chk({pwr, pdk}, {DCD_ST_PD, DCD_PD_PRECH}, "precharge pd");
      nop(1'b1);
      settle();
      go(4'h1, '0, '0);
      ctl.issue(1'b0, 4'h7, '0, '0, 1'b0);
      chk(pdk, DCD_PD_PRECH, "refresh pd");
      nop(1'b1);
      settle();
      $display("test power_down done");
      ctl.issue(1'b0, 4'h1, '0, '0, 1'b1);
      chk({cmd, pwr}, {DCD_CMD_SRE, DCD_ST_SR}, "sr entry");
      repeat (3) nop(1'b0);
      chk({stb, pwr}, {1'b0, DCD_ST_SR}, "sr holds");
      nop(1'b1);
      nop(1'b1);
      chk(pwr, DCD_ST_ACTIVE, "sr exit");
      settle();
      $display("test self_refresh done");
      for (int i = 0; i < 8; i++) begin
         r = xs();
         go({r[31], r[2:0] | {3{~r[31]}}}, r[AW+:BW], r[AW-1:0]);
      end
      go(4'h3, b, '0);
      rst_b = 1'b0;
      @(negedge clk);
      chk({stb, pwr, bop}, 0, "reset");
      rst_b = 1'b1;
      nop(1'b1);
      nop(1'b1);
      go(4'h3, b, '0);
      $display("test idle_and_reset done");
      tally_and_finish();
   end

   initial begin
      #(3000 * 50);
      n_fail++;
      $display("[ERR] %0t watchdog expired", $time);
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
